// >>> core/irq_status_pkg.sv
// Register map, field positions and reset values of the host status block
package irq_status_pkg;
   localparam logic [7:0]  STS_OFFSET      = 8'h58;
   localparam logic [7:0]  EN_OFFSET       = 8'h5C;
   localparam logic [7:0]  LEVEL_OFFSET    = 8'h68;
   localparam int          WDOG_BIT        = 15;
   localparam int          RX_ERR_BIT      = 14;
   localparam int          TX_ERR_BIT      = 13;
   localparam int          PIN_BIT         = 12;
   localparam int          OVERRUN_BIT     = 10;
   localparam int          SPACE_BIT       = 9;
   localparam int          TX_FULL_BIT     = 8;
   localparam int          TX_LEVEL_BIT    = 7;
   localparam int          DROP_BIT        = 6;
   localparam int          RX_FULL_BIT     = 4;
   localparam int          RX_LEVEL_BIT    = 3;
   localparam int          FLAG_W          = 16;
   localparam logic [15:0] FLAG_RST        = 16'h0000;
   // Bits cleared by writing one
   localparam logic [15:0] W1C_MASK        = 16'hE7D8;
   // Bits the enable register stores (reserved 11 and 5 included)
   localparam logic [15:0] EN_MASK         = 16'hFFF8;
   localparam int          SPACE_LSB       = 24;
   localparam int          TX_LVL_LSB      = 16;
   localparam int          RX_LVL_LSB      = 0;
   localparam logic [7:0]  SPACE_LVL_RST   = 8'h48;
   localparam logic [7:0]  TX_LVL_RST      = 8'h00;
   localparam logic [7:0]  RX_LVL_RST      = 8'h00;
endpackage

// >>> core/sticky_flags.sv
// Bank of sticky write-one-to-clear flags where a set beats a clear
`timescale 1ns/100ps
module sticky_flags (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] set_vec,
   input  wire logic [15:0] clr_vec,
   output logic      [15:0] flags
);
   logic [15:0] flags_ff;
   wire  [15:0] nxt_flags = ((flags_ff & ~clr_vec) | set_vec)
                            & irq_status_pkg::W1C_MASK;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_ff <= irq_status_pkg::FLAG_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   assign flags = flags_ff;
endmodule // sticky_flags

// >>> core/host_fifo_mac_irq_status.sv
// Host interrupt status low half: event flags, enables, levels and irq
//
// How it works
// RQ1 - Receive error event sets bit 14; host writes one to clear.
// RQ2 - Transmit error event sets bit 13; host writes one to clear.
// RQ3 - Bit 12 mirrors pending pin events, read-only.
// RQ4 - Write attempt into full transmit data FIFO sets bit 10; W1C.
// RQ5 - Bit 9 sets while free transmit space exceeds its level.
// RQ6 - Transmit status FIFO becoming full sets bit 8; W1C.
// RQ7 - Transmit status occupancy reaching its level sets bit 7; W1C.
// RQ8 - Each receive frame drop sets bit 6; W1C.
// RQ9 - Receive status FIFO becoming full sets bit 4.
// RQ10 - Receive status occupancy reaching its level sets bit 3.
// RQ11 - Tag growth of oversize untagged jumbo also sets watchdog bit 15.
// RQ12 - A flag raises irq only when its enable bit is one.
// RQ13 - Flags record events regardless of their enable bits.
// RQ14 - Transmit space level: bits 31:24, 64-byte blocks, resets 48h.
// RQ15 - Status levels at 23:16 and 7:0 in words, reset zero.
// RQ16 - Reserved status bits 11, 5, 2:0 read zero, ignore writes.
// RQ17 - Bits 9, 4 and 3 are also write-one-to-clear.
`timescale 1ns/100ps
module host_fifo_mac_irq_status (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             irq,
   input  wire logic        rx_error_evt,
   input  wire logic        tx_error_evt,
   input  wire logic        pin_event_pending,
   input  wire logic        tx_data_wr_attempt,
   input  wire logic        tx_data_full,
   input  wire logic [7:0]  tx_data_free_blocks,
   input  wire logic        tx_status_full,
   input  wire logic [7:0]  tx_status_used,
   input  wire logic        rx_frame_drop_evt,
   input  wire logic        rx_status_full,
   input  wire logic [7:0]  rx_status_used,
   input  wire logic        rx_oversize_evt,
   input  wire logic        jumbo_tag_grow_evt
);
   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   logic [31:0] rdata_ff;
   logic        irq_ff;
   logic        pin_ff;
   logic        tx_full_prev_ff;
   logic        rx_full_prev_ff;
   logic [15:0] en_ff;
   logic [7:0]  space_lvl_ff;
   logic [7:0]  tx_lvl_ff;
   logic [7:0]  rx_lvl_ff;
   logic [15:0] sticky;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Address decode
   wire sts_hit   = hit(reg_addr, irq_status_pkg::STS_OFFSET);
   wire en_hit    = hit(reg_addr, irq_status_pkg::EN_OFFSET);
   wire level_hit = hit(reg_addr, irq_status_pkg::LEVEL_OFFSET);
   wire sts_wr    = reg_wr && sts_hit;
   wire en_wr     = reg_wr && en_hit;
   wire level_wr  = reg_wr && level_hit;

   // Event sources, recorded whatever the enables say
   wire overrun_evt  = tx_data_wr_attempt && tx_data_full;     // [RQ4]
   wire space_evt    = tx_data_free_blocks > space_lvl_ff;     // [RQ5]
   // Full flags fire on the rising edge of full, not while it stays
   wire tx_full_evt  = tx_status_full && !tx_full_prev_ff;     // [RQ6]
   wire tx_level_evt = tx_status_used >= tx_lvl_ff;            // [RQ7]
   wire rx_full_evt  = rx_status_full && !rx_full_prev_ff;     // [RQ9]
   wire rx_level_evt = rx_status_used >= rx_lvl_ff;            // [RQ10]
   wire watchdog_evt = rx_oversize_evt || jumbo_tag_grow_evt;  // [RQ11]

   wire [15:0] set_vec = {watchdog_evt,                        // [RQ11]
                          rx_error_evt,                        // [RQ1]
                          tx_error_evt,                        // [RQ2]
                          2'b00,
                          overrun_evt,                         // [RQ4]
                          space_evt,                           // [RQ5]
                          tx_full_evt,                         // [RQ6]
                          tx_level_evt,                        // [RQ7]
                          rx_frame_drop_evt,                   // [RQ8]
                          1'b0,
                          rx_full_evt,                         // [RQ9]
                          rx_level_evt,                        // [RQ10]
                          3'b000};                             // [RQ16]

   // Clear by writing one; non-W1C and reserved bits ignore it
   wire [15:0] clr_vec = sts_wr ? reg_wdata[15:0] : 16'h0000; // [RQ17]

   sticky_flags u_flags (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_vec (set_vec),
      .clr_vec (clr_vec),
      .flags   (sticky)
   );

   // Reserved bits fall out of W1C_MASK and read zero
   wire [15:0] pin_vec = {15'h0000, pin_ff} << irq_status_pkg::PIN_BIT;
   wire [15:0] status  = sticky | pin_vec;               // [RQ3] [RQ16]

   wire [31:0] level_word = {space_lvl_ff, tx_lvl_ff, 8'h00, rx_lvl_ff};
   wire [31:0] rd_mux = sts_hit   ? {16'h0000, status} :
                        en_hit    ? {16'h0000, en_ff}  :
                        level_hit ? level_word         : 32'h0000_0000;
   wire        nxt_irq = |(status & en_ff);                      // [RQ12]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_ff          <= 1'b0;
         tx_full_prev_ff <= 1'b0;
         rx_full_prev_ff <= 1'b0;
         irq_ff          <= 1'b0;
         rdata_ff        <= 32'h0000_0000;
      end else begin
         pin_ff          <= pin_event_pending;                   // [RQ3]
         tx_full_prev_ff <= tx_status_full;
         rx_full_prev_ff <= rx_status_full;
         irq_ff          <= nxt_irq;                             // [RQ12]
         rdata_ff        <= reg_rd ? rd_mux : rdata_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_ff <= 16'h0000;
      end else if (en_wr) begin
         en_ff <= reg_wdata[15:0] & irq_status_pkg::EN_MASK;     // [RQ12]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         space_lvl_ff <= irq_status_pkg::SPACE_LVL_RST;          // [RQ14]
         tx_lvl_ff    <= irq_status_pkg::TX_LVL_RST;             // [RQ15]
         rx_lvl_ff    <= irq_status_pkg::RX_LVL_RST;             // [RQ15]
      end else if (level_wr) begin
         space_lvl_ff <= reg_wdata[irq_status_pkg::SPACE_LSB +: 8]; // [RQ14]
         tx_lvl_ff    <= reg_wdata[irq_status_pkg::TX_LVL_LSB +: 8]; // [RQ15]
         rx_lvl_ff    <= reg_wdata[irq_status_pkg::RX_LVL_LSB +: 8]; // [RQ15]
      end
   end

   assign reg_rdata = rdata_ff;
   assign irq       = irq_ff;

   // Host error flags: a set wins over a clear in the same cycle
   rx_err_set_a: assert property ( // [RQ1]
      @(posedge sys_clk) disable iff (!rst_n)
      rx_error_evt |=> status[irq_status_pkg::RX_ERR_BIT])
      else $error("rx error flag not set");
   rx_err_clr_a: assert property ( // [RQ1]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::RX_ERR_BIT] && !rx_error_evt)
      |=> !status[irq_status_pkg::RX_ERR_BIT])
      else $error("rx error flag not cleared");
   tx_err_set_a: assert property ( // [RQ2]
      @(posedge sys_clk) disable iff (!rst_n)
      tx_error_evt |=> status[irq_status_pkg::TX_ERR_BIT])
      else $error("tx error flag lost");
   tx_err_clr_a: assert property ( // [RQ2]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::TX_ERR_BIT] && !tx_error_evt)
      |=> !status[irq_status_pkg::TX_ERR_BIT])
      else $error("tx error flag not cleared");

   // Pin summary is a delayed copy that writes cannot touch
   pin_mirror_a: assert property ( // [RQ3]
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 status[irq_status_pkg::PIN_BIT] == $past(pin_event_pending))
      else $error("pin summary wrong");
   pin_nowrite_a: assert property ( // [RQ3]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::PIN_BIT] && pin_event_pending)
      |=> status[irq_status_pkg::PIN_BIT])
      else $error("pin summary cleared by write");

   // Transmit data FIFO flags
   overrun_set_a: assert property ( // [RQ4]
      @(posedge sys_clk) disable iff (!rst_n)
      (tx_data_wr_attempt && tx_data_full) |=> status[10])
      else $error("overrun not flagged");
   overrun_clr_a: assert property ( // [RQ4]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::OVERRUN_BIT] && !overrun_evt)
      |=> !status[irq_status_pkg::OVERRUN_BIT])
      else $error("overrun flag not cleared");
   space_set_a: assert property ( // [RQ5]
      @(posedge sys_clk) disable iff (!rst_n)
      (tx_data_free_blocks > space_lvl_ff) |=> status[9])
      else $error("space flag not set");
   space_clr_a: assert property ( // [RQ17]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::SPACE_BIT] && !space_evt)
      |=> !status[irq_status_pkg::SPACE_BIT])
      else $error("space flag not cleared");

   // Transmit status FIFO flags
   tx_full_edge_a: assert property ( // [RQ6]
      @(posedge sys_clk) disable iff (!rst_n)
      (tx_status_full && !tx_full_prev_ff) |=> status[8])
      else $error("tx status full missed");
   tx_full_clr_a: assert property ( // [RQ6]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::TX_FULL_BIT] && !tx_full_evt)
      |=> !status[irq_status_pkg::TX_FULL_BIT])
      else $error("tx status full not cleared");
   tx_level_set_a: assert property ( // [RQ7]
      @(posedge sys_clk) disable iff (!rst_n)
      (tx_status_used >= tx_lvl_ff) |=> status[7])
      else $error("tx status level missed");
   tx_level_clr_a: assert property ( // [RQ7]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::TX_LEVEL_BIT] && !tx_level_evt)
      |=> !status[irq_status_pkg::TX_LEVEL_BIT])
      else $error("tx status level not cleared");

   // Receive side flags and the watchdog bit
   drop_set_a: assert property ( // [RQ8]
      @(posedge sys_clk) disable iff (!rst_n)
      rx_frame_drop_evt |=> status[irq_status_pkg::DROP_BIT])
      else $error("drop missed");
   drop_clr_a: assert property ( // [RQ8]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::DROP_BIT] && !rx_frame_drop_evt)
      |=> !status[irq_status_pkg::DROP_BIT])
      else $error("drop flag not cleared");
   rx_full_edge_a: assert property ( // [RQ9]
      @(posedge sys_clk) disable iff (!rst_n)
      (rx_status_full && !rx_full_prev_ff) |=> status[4])
      else $error("rx status full missed");
   rx_full_clr_a: assert property ( // [RQ17]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::RX_FULL_BIT] && !rx_full_evt)
      |=> !status[irq_status_pkg::RX_FULL_BIT])
      else $error("rx status full not cleared");
   rx_level_set_a: assert property ( // [RQ10]
      @(posedge sys_clk) disable iff (!rst_n)
      (rx_status_used >= rx_lvl_ff) |=> status[3])
      else $error("rx status level missed");
   rx_level_clr_a: assert property ( // [RQ17]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::RX_LEVEL_BIT] && !rx_level_evt)
      |=> !status[irq_status_pkg::RX_LEVEL_BIT])
      else $error("rx level flag not cleared");
   wdog_jumbo_a: assert property ( // [RQ11]
      @(posedge sys_clk) disable iff (!rst_n)
      jumbo_tag_grow_evt |=> status[irq_status_pkg::WDOG_BIT])
      else $error("jumbo tag case missed");
   wdog_clr_a: assert property ( // [RQ11]
      @(posedge sys_clk) disable iff (!rst_n)
      (clr_vec[irq_status_pkg::WDOG_BIT] && !watchdog_evt)
      |=> !status[irq_status_pkg::WDOG_BIT])
      else $error("watchdog flag not cleared");

   // Interrupt request and enables
   irq_gate_a: assert property ( // [RQ12]
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 irq == $past(|(status & en_ff)))
      else $error("irq does not follow enabled flags");
   irq_quiet_a: assert property ( // [RQ12]
      @(posedge sys_clk) disable iff (!rst_n)
      (en_ff == 16'h0000) |=> !irq)
      else $error("irq raised with all enables off");
   masked_rec_a: assert property ( // [RQ13]
      @(posedge sys_clk) disable iff (!rst_n)
      (rx_error_evt && !en_ff[14]) |=> status[14])
      else $error("masked event not recorded");
   enable_mask_a: assert property ( // [RQ12]
      @(posedge sys_clk) disable iff (!rst_n)
      (en_ff & ~irq_status_pkg::EN_MASK) == 16'h0000)
      else $error("unstored enable bit set");
   enable_write_a: assert property ( // [RQ12]
      @(posedge sys_clk) disable iff (!rst_n)
      en_wr |=> en_ff ==
      ($past(reg_wdata[15:0]) & irq_status_pkg::EN_MASK))
      else $error("enable write lost");

   // Level register and reserved bits
   lvl_reset_a: assert property ( // [RQ14]
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> space_lvl_ff == irq_status_pkg::SPACE_LVL_RST
      && tx_lvl_ff == irq_status_pkg::TX_LVL_RST
      && rx_lvl_ff == irq_status_pkg::RX_LVL_RST)
      else $error("level reset values wrong");
   lvl_write_a: assert property ( // [RQ15]
      @(posedge sys_clk) disable iff (!rst_n)
      level_wr |=> tx_lvl_ff ==
      $past(reg_wdata[irq_status_pkg::TX_LVL_LSB +: 8]))
      else $error("tx status level write lost");
   reserved_a: assert property ( // [RQ16]
      @(posedge sys_clk) disable iff (!rst_n)
      status[11] == 1'b0 && status[5] == 1'b0 && status[2:0] == 3'b000)
      else $error("reserved status bit set");
   unmapped_rd_a: assert property ( // [RQ16]
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && !sts_hit && !en_hit && !level_hit) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   level_gap_a: assert property ( // [RQ15]
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && level_hit) |=> reg_rdata[15:8] == 8'h00)
      else $error("unused level bits not zero");
endmodule // host_fifo_mac_irq_status

// >>> tb/host_cpu_model.sv
// Host CPU model driving single-cycle register strobes
`timescale 1ns/100ps
module host_cpu_model (
   input  wire logic        sys_clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [7:0]  reg_addr,
   output logic      [31:0] reg_wdata,
   input  wire logic [31:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
   end
   // Strobe launched on a falling edge, taken on the next rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // Registered data is settled one falling edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule // host_cpu_model

// >>> tb/test_host_fifo_mac_irq_status.sv
// Self-checking bench for the host status flag block
`timescale 1ns/100ps
module test_host_fifo_mac_irq_status;
   logic        sys_clk, arst_n, reg_wr, reg_rd, irq;
   logic        rx_error_evt, tx_error_evt, pin_event_pending;
   logic        tx_data_wr_attempt, tx_data_full, tx_status_full;
   logic        rx_frame_drop_evt, rx_status_full;
   logic        rx_oversize_evt, jumbo_tag_grow_evt;
   logic [7:0]  tx_data_free_blocks, tx_status_used, rx_status_used;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   int          num_errors = 0;
   int          check_count = 0;
   host_cpu_model cpu_u (.sys_clk, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata);
   host_fifo_mac_irq_status dut_u (.sys_clk, .arst_n, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .irq, .rx_error_evt,
      .tx_error_evt, .pin_event_pending, .tx_data_wr_attempt,
      .tx_data_full, .tx_data_free_blocks, .tx_status_full,
      .tx_status_used, .rx_frame_drop_evt, .rx_status_full,
      .rx_status_used, .rx_oversize_evt, .jumbo_tag_grow_evt);
   task automatic idle;
      {rx_error_evt, tx_error_evt, pin_event_pending} = 3'h0;
      {tx_data_wr_attempt, tx_data_full, tx_status_full} = 3'h0;
      {rx_frame_drop_evt, rx_status_full} = 2'h0;
      {rx_oversize_evt, jumbo_tag_grow_evt} = 2'h0;
      {tx_data_free_blocks, tx_status_used, rx_status_used} = 24'h0;
   endtask
   task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(string n, logic e);
      check_count++;
      if (irq !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, irq);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_reset;
      cpu_u.rd(irq_status_pkg::LEVEL_OFFSET, v);
      chk32("level", 32'h4800_0000, v);
      cpu_u.rd(irq_status_pkg::EN_OFFSET, v);
      chk32("enable", 32'h0, v);
      cpu_u.wr(irq_status_pkg::LEVEL_OFFSET, 32'h4805_AA05);
      cpu_u.rd(irq_status_pkg::LEVEL_OFFSET, v);
      chk32("level", 32'h4805_0005, v);
      cpu_u.wr(irq_status_pkg::STS_OFFSET, 32'hFFFF_FFFF);
      cpu_u.rd(irq_status_pkg::STS_OFFSET, v);
      chk32("status", 32'h0, v);
      cpu_u.rd(8'h60, v);
      chk32("unmapped", 32'h0, v);
   endtask
   task automatic t_events;
      logic [15:0] e [14] = '{16'h4000, 16'h2000, 16'h0400, 16'h0,
         16'h0200, 16'h0, 16'h0100, 16'h0080, 16'h0, 16'h0040,
         16'h0010, 16'h0008, 16'h8000, 16'h8000};
      for (int i = 0; i < 14; i++) begin
         @(negedge sys_clk);
         case (i)
            0: rx_error_evt = 1'b1;
            1: tx_error_evt = 1'b1;
            2: {tx_data_wr_attempt, tx_data_full} = 2'h3;
            3: tx_data_wr_attempt = 1'b1;
            4: tx_data_free_blocks = 8'h49;
            5: tx_data_free_blocks = 8'h48;
            6: tx_status_full = 1'b1;
            7: tx_status_used = 8'h05;
            8: tx_status_used = 8'h04;
            9: rx_frame_drop_evt = 1'b1;
            10: rx_status_full = 1'b1;
            11: rx_status_used = 8'h05;
            12: rx_oversize_evt = 1'b1;
            default: jumbo_tag_grow_evt = 1'b1;
         endcase
         @(negedge sys_clk);
         idle();
         cpu_u.rd(irq_status_pkg::STS_OFFSET, v);
         chk32("event flag", {16'h0, e[i]}, v);
         cpu_u.wr(irq_status_pkg::STS_OFFSET, 32'h0000_FFFF);
         cpu_u.rd(irq_status_pkg::STS_OFFSET, v);
         chk32("cleared flag", 32'h0, v);
      end
   endtask
   task automatic t_pin;
      @(negedge sys_clk);
      pin_event_pending = 1'b1;
      cpu_u.wr(irq_status_pkg::STS_OFFSET, 32'h0000_1000);
      cpu_u.rd(irq_status_pkg::STS_OFFSET, v);
      chk32("pin bit", 32'h0000_1000, v);
      pin_event_pending = 1'b0;
      cpu_u.rd(irq_status_pkg::STS_OFFSET, v);
      chk32("pin bit", 32'h0, v);
   endtask
   task automatic t_irq;
      cpu_u.wr(irq_status_pkg::EN_OFFSET, 32'hFFFF_FFFF);
      cpu_u.rd(irq_status_pkg::EN_OFFSET, v);
      chk32("enable", 32'h0000_FFF8, v);
      cpu_u.wr(irq_status_pkg::EN_OFFSET, 32'h0000_2000);
      @(negedge sys_clk);
      rx_error_evt = 1'b1;
      @(negedge sys_clk);
      rx_error_evt = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk1("masked irq", 1'b0);
      cpu_u.wr(irq_status_pkg::EN_OFFSET, 32'h0000_4000);
      repeat (2) @(negedge sys_clk);
      chk1("enabled irq", 1'b1);
      cpu_u.wr(irq_status_pkg::STS_OFFSET, 32'h0000_4000);
      repeat (2) @(negedge sys_clk);
      chk1("cleared irq", 1'b0);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      complete_run();
   end
   initial begin
      arst_n = 1'b0;
      idle();
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_events();
      t_pin();
      t_irq();
      complete_run();
   end
endmodule // test_host_fifo_mac_irq_status
